// File: rtl/nibble_defs.svh
`ifndef NIBBLE_DEFS_SVH
`define NIBBLE_DEFS_SVH
// Function
// - Consecutive immediate accumulator loads: only the first runs, later ones are skipped.
// - Table read loads D, B, A from ROM word at page p, D:A; uses one stack level.
// - Add memory nibble to accumulator, carry flag unchanged.
// - Add memory nibble and carry to accumulator, carry out into carry flag.
// - Add immediate, carry unchanged; skip next when no overflow.
// - Bitwise AND or OR of accumulator with memory nibble, result to accumulator.
// - Set carry and clear carry instructions touch nothing else.
// - Skip next instruction when carry flag is zero.
// - Accumulator becomes its one's complement, carry unchanged.
// - Rotate carry and accumulator right; bit 0 to carry, carry to bit 3.
// - Set or clear memory bit j, other bits kept.
// - Skip next when memory bit j is zero.
// - Skip next when accumulator equals memory nibble or the immediate.
// - Short branch loads low program counter with a, page kept.
// - Two-word long branch loads page p and low part a.
// - Indirect long branch jumps to page p, low part from D and accumulator.
// - Short call pushes return address, page 2, low part a.
// - Two-word long call pushes return address, jumps to page p, address a.
// - Indirect long call pushes return, jumps to page p at D:accumulator.
// - Interrupt return pops pc and restores pointer, carry, skip, load state, A, B.
// - Subroutine returns pop pc in two cycles; skipping variant skips next.
// - Request tests skip and clear flag when flag is set and control bit is zero, else no-op.
// - Disable and enable instructions clear and set global interrupt enable.
// - Pin tests skip when pin level matches polarity bit.

// opcode patterns, each compared against as many leading bits of the word as it has
`define OP_LOAD_ACC_IMM 6'h07
`define OP_ROM_TABLE_READ 4'h2
`define OP_ADD_MEM 10'h00A
`define OP_ADD_MEM_CARRY 10'h00B
`define OP_ADD_IMM 6'h06
`define OP_AND_MEM 10'h018
`define OP_OR_MEM 10'h019
`define OP_SET_CARRY 10'h007
`define OP_CLEAR_CARRY 10'h006
`define OP_SKIP_IF_CARRY_ZERO 10'h02F
`define OP_COMPLEMENT_ACC 10'h01C
`define OP_ROTATE_RIGHT_CARRY 10'h01D
`define OP_SET_MEM_BIT 8'h17
`define OP_CLEAR_MEM_BIT 8'h13
`define OP_SKIP_IF_BIT_ZERO 8'h08
`define OP_SKIP_IF_ACC_EQ_MEM 10'h026
`define OP_SKIP_IF_ACC_EQ_IMM 10'h025
`define OP_SHORT_BRANCH 3'h3
`define OP_LONG_BRANCH 5'h07
`define OP_INDIRECT_LONG_BRANCH 10'h010
`define OP_SHORT_CALL 3'h2
`define OP_LONG_CALL 5'h06
`define OP_INDIRECT_LONG_CALL 10'h030
`define OP_INTERRUPT_RETURN 10'h046
`define OP_SUB_RETURN 10'h044
`define OP_SUB_RETURN_SKIP 10'h045
`define OP_IRQ_DISABLE 10'h004
`define OP_IRQ_ENABLE 10'h005
`define OP_TEST_EXT_REQ_0 10'h038
`define OP_TEST_EXT_REQ_1 10'h039
`define OP_TEST_EXT_PIN_0 10'h03A
`define OP_TEST_EXT_PIN_1 10'h03B

// fixed values
`define SHORT_CALL_PAGE 6'h02
`define SP_RESET 3'h7
`define PC_RESET 13'h0000
`define STACK_DEPTH 8

// register byte offsets
`define REG_CTRL 12'h000
`define REG_DPTR 12'h004
`define REG_STATUS 12'h008
`define REG_PC 12'h00C

// control register fields
`define CTRL_RUN 0
`define CTRL_EXT0_TEST 1
`define CTRL_EXT1_TEST 2
`define CTRL_EXT0_POL 3
`define CTRL_EXT1_POL 4
`define CTRL_RESET 5'h00
`endif

// File: rtl/nibble_pkg.sv
`default_nettype none
package nibble_pkg;
	typedef enum logic [4:0] {
		ST_EXEC = 5'h01,
		ST_WORD2 = 5'h02,
		ST_SKIP2 = 5'h04,
		ST_TABLE = 5'h08,
		ST_TAIL = 5'h10
	} exec_state_type;

	typedef enum logic [3:0] {
		ALU_PASS, ALU_ADD, ALU_ADC, ALU_ADDI, ALU_AND, ALU_OR,
		ALU_CMA, ALU_RAR, ALU_SETB, ALU_CLRB
	} alu_op_type;
endpackage
`default_nettype wire

// File: rtl/nibble_alu.sv
`default_nettype none
module nibble_alu (
	input wire nibble_pkg::alu_op_type op_in,
	input wire logic [3:0] acc_in,
	input wire logic [3:0] mem_in,
	input wire logic carry_in,
	input wire logic [3:0] imm_in,
	input wire logic [1:0] bit_sel_in,
	output logic [3:0] result_out,
	output logic carry_out,
	output logic overflow_out
);
	import nibble_pkg::*;

	logic [4:0] sum_mem;
	logic [4:0] sum_mem_carry;
	logic [4:0] sum_imm;
	logic [3:0] bit_mask;

	// sums at five bits so the carry is kept
	assign sum_mem = {1'b0, acc_in} + {1'b0, mem_in};
	assign sum_mem_carry = sum_mem + {4'h0, carry_in};
	assign sum_imm = {1'b0, acc_in} + {1'b0, imm_in};
	assign bit_mask = 4'h1 << bit_sel_in;

	// result select
	always_comb begin
		result_out = acc_in;
		carry_out = carry_in;
		overflow_out = sum_imm[4];
		case (op_in)
			ALU_ADD: result_out = sum_mem[3:0];
			ALU_ADC: begin
				result_out = sum_mem_carry[3:0];
				carry_out = sum_mem_carry[4];
			end
			ALU_ADDI: result_out = sum_imm[3:0];
			ALU_AND: result_out = acc_in & mem_in;
			ALU_OR: result_out = acc_in | mem_in;
			ALU_CMA: result_out = ~acc_in;
			ALU_RAR: begin
				result_out = {carry_in, acc_in[3:1]};
				carry_out = acc_in[0];
			end
			ALU_SETB: result_out = mem_in | bit_mask;
			ALU_CLRB: result_out = mem_in & ~bit_mask;
			default: result_out = acc_in;
		endcase
	end
endmodule // nibble_alu
`default_nettype wire

// File: rtl/nibble_cpu_alu_branch_exec.sv
`include "nibble_defs.svh"
`default_nettype none
module nibble_cpu_alu_branch_exec (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [11:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic [12:0] rom_addr_out,
	input wire logic [9:0] rom_data_in,
	output logic [9:0] ram_addr_out,
	input wire logic [3:0] ram_rd_data_in,
	output logic ram_wr_en_out,
	output logic [3:0] ram_wr_data_out,
	input wire logic ext_irq_pin_0_in,
	input wire logic ext_irq_pin_1_in,
	input wire logic ext_req_set_0_in,
	input wire logic ext_req_set_1_in,
	input wire logic irq_take_in,
	input wire logic [12:0] irq_vector_in,
	output logic irq_ack_out,
	output logic global_irq_enable_out
);
	import nibble_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state
	exec_state_type state, next_state;
	logic [12:0] pc, next_pc, next_rom_addr;
	logic [3:0] acc, next_acc;
	logic [3:0] breg, next_breg;
	logic [2:0] dreg, next_dreg;
	logic carry_flag, next_carry;
	logic skip, next_skip;
	logic la_run, next_la_run;
	logic [2:0] stack_pointer, next_sp;
	logic [12:0] stack [`STACK_DEPTH];
	logic [9:0] first_word;
	logic [3:0] x_ptr, y_ptr;
	logic [1:0] z_ptr;
	logic ext_req_flag_0, ext_req_flag_1;
	logic [4:0] ctrl;
	logic [3:0] sh_acc, sh_breg, sh_x, sh_y;
	logic [1:0] sh_z;
	logic sh_carry, sh_skip, sh_la;
	logic push_en, clr_req_0, clr_req_1, restore, save, next_global_irq_enable_flag;
	logic [12:0] push_val;
	logic next_ram_we;
	alu_op_type alu_op;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [12:0] pc_inc(input logic [12:0] val);
		pc_inc = {val[12:7], val[6:0] + 7'h01}; // counts within the page
	endfunction

	function automatic logic [12:0] indirect_target(input logic [5:0] page,
		input logic [2:0] d, input logic [3:0] a);
		indirect_target = {page, d, a};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// decode of the word on the ROM bus
	logic [9:0] w;
	logic [3:0] mem_val;
	logic is_la, is_table, is_addi, is_setb, is_clrb, is_szb, is_sbr, is_sbl, is_scall, is_lcall;
	logic is_two_word, is_bla, is_indirect_long_call, is_sea, w2_bl, w2_bml, w2_bla, w2_indirect_long_call, w2_sea;
	logic [5:0] w2_page_direct, w2_page_indirect;
	logic [3:0] alu_res;
	logic alu_carry, alu_ovf, mem_bit;
	logic pin0_match, pin1_match, run, take_irq;

	assign w = rom_data_in;
	// a write still in flight lands on the same nibble, so forward it
	assign mem_val = ram_wr_en_out ? ram_wr_data_out : ram_rd_data_in;
	assign is_la = (w[9:4] == `OP_LOAD_ACC_IMM);
	assign is_table = (w[9:6] == `OP_ROM_TABLE_READ);
	assign is_addi = (w[9:4] == `OP_ADD_IMM);
	assign is_setb = (w[9:2] == `OP_SET_MEM_BIT);
	assign is_clrb = (w[9:2] == `OP_CLEAR_MEM_BIT);
	assign is_szb = (w[9:2] == `OP_SKIP_IF_BIT_ZERO);
	assign is_sbr = (w[9:7] == `OP_SHORT_BRANCH);
	assign is_sbl = (w[9:5] == `OP_LONG_BRANCH);
	assign is_scall = (w[9:7] == `OP_SHORT_CALL);
	assign is_lcall = (w[9:5] == `OP_LONG_CALL);
	assign is_bla = (w == `OP_INDIRECT_LONG_BRANCH);
	assign is_indirect_long_call = (w == `OP_INDIRECT_LONG_CALL);
	assign is_sea = (w == `OP_SKIP_IF_ACC_EQ_IMM);
	assign is_two_word = is_sbl | is_lcall | is_bla | is_indirect_long_call | is_sea;
	// first word held for the second cycle of a two-word instruction
	assign w2_bl = (first_word[9:5] == `OP_LONG_BRANCH);
	assign w2_bml = (first_word[9:5] == `OP_LONG_CALL);
	assign w2_bla = (first_word == `OP_INDIRECT_LONG_BRANCH);
	assign w2_indirect_long_call = (first_word == `OP_INDIRECT_LONG_CALL);
	assign w2_sea = (first_word == `OP_SKIP_IF_ACC_EQ_IMM);
	assign w2_page_direct = {w[7], first_word[4:0]};
	assign w2_page_indirect = {w[7:6], w[3:0]};
	assign mem_bit = mem_val[w[1:0]];
	assign pin0_match = (ext_irq_pin_0_in == ctrl[`CTRL_EXT0_POL]);
	assign pin1_match = (ext_irq_pin_1_in == ctrl[`CTRL_EXT1_POL]);
	assign run = ctrl[`CTRL_RUN];
	assign take_irq = run & irq_take_in & global_irq_enable_out & (state == ST_EXEC);

	// operation picked for the shared arithmetic unit
	assign alu_op = (w == `OP_ADD_MEM) ? ALU_ADD :
		(w == `OP_ADD_MEM_CARRY) ? ALU_ADC :
		is_addi ? ALU_ADDI :
		(w == `OP_AND_MEM) ? ALU_AND :
		(w == `OP_OR_MEM) ? ALU_OR :
		(w == `OP_COMPLEMENT_ACC) ? ALU_CMA :
		(w == `OP_ROTATE_RIGHT_CARRY) ? ALU_RAR :
		is_setb ? ALU_SETB :
		is_clrb ? ALU_CLRB : ALU_PASS;

	nibble_alu alu (
		.op_in(alu_op),
		.acc_in(acc),
		.mem_in(mem_val),
		.carry_in(carry_flag),
		.imm_in(w[3:0]),
		.bit_sel_in(w[1:0]),
		.result_out(alu_res),
		.carry_out(alu_carry),
		.overflow_out(alu_ovf)
	);

	////////////////////////////////////////////////////////////////////////////
	// next-state of the execution unit
	always_comb begin
		next_state = state;
		next_pc = pc;
		next_rom_addr = rom_addr_out;
		next_acc = acc;
		next_breg = breg;
		next_dreg = dreg;
		next_carry = carry_flag;
		next_skip = skip;
		next_la_run = la_run;
		next_sp = stack_pointer;
		next_global_irq_enable_flag = global_irq_enable_out;
		push_en = 1'b0;
		push_val = pc_inc(pc);
		clr_req_0 = 1'b0;
		clr_req_1 = 1'b0;
		restore = 1'b0;
		save = 1'b0;
		next_ram_we = 1'b0;
		case (state)
			ST_EXEC: begin
				if (!run) begin
					next_state = ST_EXEC;
				end else if (take_irq) begin
					save = 1'b1;
					push_en = 1'b1;
					push_val = pc;
					next_sp = stack_pointer + 3'h1;
					next_pc = irq_vector_in;
					next_rom_addr = irq_vector_in;
					next_global_irq_enable_flag = 1'b0;
					next_skip = 1'b0;
					next_la_run = 1'b0;
				end else begin
					next_pc = pc_inc(pc);
					next_rom_addr = pc_inc(pc);
					next_skip = 1'b0;
					next_la_run = 1'b0;
					if (skip) begin
						// skipped word has no effect; a two-word one drops its tail too
						if (is_two_word) begin
							next_state = ST_SKIP2;
						end
					end else if (is_la) begin
						if (la_run) begin
							next_la_run = 1'b1;
						end else begin
							next_acc = w[3:0];
							next_la_run = 1'b1;
						end
					end else if (is_table) begin
						push_en = 1'b1;
						next_sp = stack_pointer + 3'h1;
						next_rom_addr = indirect_target(w[5:0], dreg, acc);
						next_state = ST_TABLE;
					end else if (is_setb | is_clrb) begin
						next_ram_we = 1'b1;
					end else if (is_szb) begin
						next_skip = ~mem_bit;
					end else if (is_addi) begin
						next_acc = alu_res;
						next_skip = ~alu_ovf;
					end else if (alu_op != ALU_PASS) begin
						next_acc = alu_res;
						next_carry = alu_carry;
					end else if (is_sbr) begin
						next_pc = {pc[12:7], w[6:0]};
						next_rom_addr = {pc[12:7], w[6:0]};
					end else if (is_scall) begin
						push_en = 1'b1;
						next_sp = stack_pointer + 3'h1;
						next_pc = {`SHORT_CALL_PAGE, w[6:0]};
						next_rom_addr = {`SHORT_CALL_PAGE, w[6:0]};
					end else if (is_two_word) begin
						next_state = ST_WORD2;
					end else begin
						case (w)
							`OP_SET_CARRY: next_carry = 1'b1;
							`OP_CLEAR_CARRY: next_carry = 1'b0;
							`OP_SKIP_IF_CARRY_ZERO: next_skip = ~carry_flag;
							`OP_SKIP_IF_ACC_EQ_MEM: next_skip = (acc == mem_val);
							`OP_IRQ_DISABLE: next_global_irq_enable_flag = 1'b0;
							`OP_IRQ_ENABLE: next_global_irq_enable_flag = 1'b1;
							`OP_TEST_EXT_REQ_0: begin
								next_skip = ~ctrl[`CTRL_EXT0_TEST] & ext_req_flag_0;
								clr_req_0 = ~ctrl[`CTRL_EXT0_TEST] & ext_req_flag_0;
							end
							`OP_TEST_EXT_REQ_1: begin
								next_skip = ~ctrl[`CTRL_EXT1_TEST] & ext_req_flag_1;
								clr_req_1 = ~ctrl[`CTRL_EXT1_TEST] & ext_req_flag_1;
							end
							`OP_TEST_EXT_PIN_0: next_skip = pin0_match;
							`OP_TEST_EXT_PIN_1: next_skip = pin1_match;
							`OP_SUB_RETURN, `OP_SUB_RETURN_SKIP, `OP_INTERRUPT_RETURN: begin
								next_pc = stack[stack_pointer];
								next_rom_addr = stack[stack_pointer];
								next_sp = stack_pointer - 3'h1;
								next_skip = (w == `OP_SUB_RETURN_SKIP);
								next_state = ST_TAIL;
								if (w == `OP_INTERRUPT_RETURN) begin
									restore = 1'b1;
									next_acc = sh_acc;
									next_breg = sh_breg;
									next_carry = sh_carry;
									next_skip = sh_skip;
									next_la_run = sh_la;
								end
							end
							default: next_skip = 1'b0;
						endcase
					end
				end
			end
			ST_WORD2: begin
				next_pc = pc_inc(pc);
				next_rom_addr = pc_inc(pc);
				next_state = ST_EXEC;
				if (w2_sea) begin
					next_skip = (acc == w[3:0]);
				end else if (w2_bl | w2_bml) begin
					next_pc = {w2_page_direct, w[6:0]};
					next_rom_addr = {w2_page_direct, w[6:0]};
				end else if (w2_bla | w2_indirect_long_call) begin
					next_pc = indirect_target(w2_page_indirect, dreg, acc);
					next_rom_addr = indirect_target(w2_page_indirect, dreg, acc);
				end
				if (w2_bml | w2_indirect_long_call) begin
					push_en = 1'b1;
					next_sp = stack_pointer + 3'h1;
				end
			end
			ST_SKIP2: begin
				next_pc = pc_inc(pc);
				next_rom_addr = pc_inc(pc);
				next_state = ST_EXEC;
			end
			ST_TABLE: begin
				next_dreg = {1'b0, w[9:8]};
				next_breg = w[7:4];
				next_acc = w[3:0];
				next_pc = stack[stack_pointer];
				next_rom_addr = stack[stack_pointer];
				next_sp = stack_pointer - 3'h1;
				next_state = ST_TAIL;
			end
			ST_TAIL: next_state = ST_EXEC; // last cycle of returns and table reads
			default: next_state = ST_EXEC;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// core registers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_EXEC;
			pc <= `PC_RESET;
			rom_addr_out <= `PC_RESET;
			acc <= 4'h0;
			breg <= 4'h0;
			dreg <= 3'h0;
			carry_flag <= 1'b0;
			skip <= 1'b0;
			la_run <= 1'b0;
			stack_pointer <= `SP_RESET;
			first_word <= 10'h000;
			global_irq_enable_out <= 1'b0;
			irq_ack_out <= 1'b0;
			ram_wr_en_out <= 1'b0;
			ram_wr_data_out <= 4'h0;
		end else begin
			state <= next_state;
			pc <= next_pc;
			rom_addr_out <= next_rom_addr;
			acc <= next_acc;
			breg <= next_breg;
			dreg <= next_dreg;
			carry_flag <= next_carry;
			skip <= next_skip;
			la_run <= next_la_run;
			stack_pointer <= next_sp;
			first_word <= (state == ST_EXEC) ? w : first_word;
			global_irq_enable_out <= next_global_irq_enable_flag;
			irq_ack_out <= save;
			ram_wr_en_out <= next_ram_we;
			ram_wr_data_out <= next_ram_we ? alu_res : ram_wr_data_out;
		end
	end

	// return stack, written at the slot the pointer moves to
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < `STACK_DEPTH; i++) begin
				stack[i] <= 13'h0000;
			end
		end else if (push_en) begin
			stack[next_sp] <= push_val;
		end
	end

	// interrupt shadow, caught on entry and read back on return
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			{sh_acc, sh_breg, sh_x, sh_y, sh_z} <= 18'h0_0000;
			{sh_carry, sh_skip, sh_la} <= 3'h0;
		end else if (save) begin
			{sh_acc, sh_breg, sh_x, sh_y, sh_z} <= {acc, breg, x_ptr, y_ptr, z_ptr};
			{sh_carry, sh_skip, sh_la} <= {carry_flag, skip, la_run};
		end
	end

	// request flags: a new request wins over a clear in the same cycle
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ext_req_flag_0 <= 1'b0;
			ext_req_flag_1 <= 1'b0;
		end else begin
			ext_req_flag_0 <= ext_req_set_0_in | (ext_req_flag_0 & ~clr_req_0);
			ext_req_flag_1 <= ext_req_set_1_in | (ext_req_flag_1 & ~clr_req_1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb slave, one wait-free access phase
	logic apb_setup, apb_write, hit_ctrl, hit_dptr, hit_status, hit_pc, hit_any;
	logic [31:0] rd_mux;

	assign apb_setup = psel_in & ~penable_in;
	assign apb_write = psel_in & penable_in & pready_out & pwrite_in & ~pslverr_out;
	assign hit_ctrl = (paddr_in == `REG_CTRL);
	assign hit_dptr = (paddr_in == `REG_DPTR);
	assign hit_status = (paddr_in == `REG_STATUS);
	assign hit_pc = (paddr_in == `REG_PC);
	assign hit_any = hit_ctrl | hit_dptr | hit_status | hit_pc;
	assign rd_mux = hit_ctrl ? {27'h000_0000, ctrl} :
		hit_dptr ? {22'h00_0000, z_ptr, y_ptr, x_ptr} :
		hit_status ? {12'h000, stack_pointer, ext_req_flag_1, ext_req_flag_0,
			global_irq_enable_out, la_run, skip, carry_flag, dreg, breg, acc} :
		hit_pc ? {14'h0000, state, pc} : 32'h0000_0000;
	assign ram_addr_out = {z_ptr, x_ptr, y_ptr};

	// answer registered from the setup cycle
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end else begin
			pready_out <= apb_setup;
			pslverr_out <= apb_setup & (~hit_any | (pwrite_in & (hit_status | hit_pc)));
			prdata_out <= (apb_setup & ~pwrite_in) ? rd_mux : 32'h0000_0000;
		end
	end

	// software registers; a return from interrupt restores the pointer
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl <= `CTRL_RESET;
			x_ptr <= 4'h0;
			y_ptr <= 4'h0;
			z_ptr <= 2'h0;
		end else begin
			if (apb_write & hit_ctrl) begin
				ctrl <= pwdata_in[4:0];
			end
			if (restore) begin
				{x_ptr, y_ptr, z_ptr} <= {sh_x, sh_y, sh_z};
			end else if (apb_write & hit_dptr) begin
				{z_ptr, y_ptr, x_ptr} <= pwdata_in[9:0];
			end
		end
	end
endmodule // nibble_cpu_alu_branch_exec
`default_nettype wire

// File: bench/exec_checker.sv
`default_nettype none
module exec_checker (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [11:0] paddr_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [12:0] rom_addr_out,
	input wire logic [9:0] rom_data_in,
	input wire logic [3:0] ram_rd_data_in,
	input wire logic ram_wr_en_out,
	input wire logic [3:0] ram_wr_data_out
);
	logic run_q;
	logic [1:0] halt_cnt;
	logic [12:0] prev_addr;
	logic [9:0] prev_data;
	// completed apb transfer and the in-page successor of the last fetch
	wire apb_done = psel_in && penable_in && pready_out;
	wire [12:0] next_seq = {prev_addr[12:7], prev_addr[6:0] + 7'h01};
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	////////////////////////////////////////////////////////////////
	// mirror the run bit, count halted cycles, keep the last fetch
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_q <= 1'b0;
			halt_cnt <= 2'h0;
			prev_addr <= 13'h0000;
			prev_data <= 10'h000;
		end else begin
			run_q <= (apb_done && pwrite_in && paddr_in == 12'h000) ? pwdata_in[0] : run_q;
			halt_cnt <= run_q ? 2'h0 : ((halt_cnt == 2'h3) ? 2'h3 : halt_cnt + 2'h1);
			prev_addr <= rom_addr_out;
			prev_data <= rom_data_in;
		end
	end
	////////////////////////////////////////////////////////////////
	a_ready_setup: assert property (psel_in && !penable_in |=> pready_out)
		else $error("no answer one cycle after setup");
	a_ready_access: assert property (pready_out |-> psel_in && penable_in && $past(!penable_in))
		else $error("stray ready");
	a_err_unmapped: assert property (apb_done && paddr_in > 12'h00c |->
		pslverr_out && prdata_out == 32'h0000_0000) else $error("unmapped access accepted");
	a_err_readonly: assert property (apb_done && pwrite_in && paddr_in[3] |-> pslverr_out)
		else $error("read-only write accepted");
	a_idle_rdata: assert property (!pready_out |-> prdata_out == 32'h0000_0000)
		else $error("stray read data");
	a_bit_one: assert property (ram_wr_en_out |-> $countones(ram_wr_data_out ^ ram_rd_data_in) < 2)
		else $error("bit write touched more than one bit");
	a_halt_quiet: assert property (halt_cnt == 2'h3 |-> !ram_wr_en_out && $stable(rom_addr_out))
		else $error("halted core still active");
	a_short_branch: assert property (run_q && rom_data_in[9:7] == 3'h3 |=>
		rom_addr_out == {prev_addr[12:7], prev_data[6:0]} || rom_addr_out == next_seq ||
		rom_addr_out == prev_addr) else $error("short branch left its page");
	a_short_call: assert property (run_q && rom_data_in[9:7] == 3'h2 |=>
		rom_addr_out == {6'h02, prev_data[6:0]} || rom_addr_out == next_seq ||
		rom_addr_out == prev_addr) else $error("short call target wrong");
	a_long_branch: assert property (run_q && rom_data_in[9:8] == 2'h2 &&
		prev_data[9:5] == 5'h07 && rom_addr_out == next_seq |=>
		rom_addr_out == {prev_data[7], $past(prev_data[4:0]), prev_data[6:0]} ||
		rom_addr_out == next_seq || rom_addr_out == prev_addr) else $error("long branch target wrong");
endmodule // exec_checker

bind nibble_cpu_alu_branch_exec exec_checker exec_checker_i (.*);
`default_nettype wire

// File: bench/program_mem_model.sv
`default_nettype none
module program_mem_model (
	input wire logic clk_in,
	input wire logic [12:0] rom_addr_in,
	output logic [9:0] rom_data_out,
	input wire logic [9:0] ram_addr_in,
	output logic [3:0] ram_rd_data_out,
	input wire logic ram_wr_en_in,
	input wire logic [3:0] ram_wr_data_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] rom [0:8191];
	logic [3:0] ram [0:1023];
	// blank program words decode as no-op, so stray fetches stay harmless
	initial begin
		for (int i = 0; i < 8192; i++) begin
			rom[i] = 10'h000;
			ram[i % 1024] = 4'h0;
		end
	end
	// both memories answer in the same cycle
	assign rom_data_out = rom[rom_addr_in];
	assign ram_rd_data_out = ram[ram_addr_in];
	// a strobed write lands at the end of its cycle
	always @(posedge clk_in) begin
		if (ram_wr_en_in) begin
			ram[ram_addr_in] <= ram_wr_data_in;
		end
	end
endmodule // program_mem_model
`default_nettype wire

// File: bench/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, ext_irq_pin_0_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0000_0000;
	logic [31:0] prdata_out, rd;
	logic pready_out, pslverr_out, ram_wr_en_out, irq_ack_out, global_irq_enable_out, err;
	logic [12:0] rom_addr_out;
	logic [9:0] rom_data_in, ram_addr_out;
	logic [3:0] ram_rd_data_in, ram_wr_data_out;
	int errors = 0;
	int num_checks = 0;
	int k;
	always #5 sys_clk_in = ~sys_clk_in;
	nibble_cpu_alu_branch_exec nibble_cpu_alu_branch_exec_i (.sys_clk_in, .rst_n_in, .paddr_in,
		.psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
		.rom_addr_out, .rom_data_in, .ram_addr_out, .ram_rd_data_in, .ram_wr_en_out,
		.ram_wr_data_out, .ext_irq_pin_0_in, .ext_irq_pin_1_in(1'b0), .ext_req_set_0_in(1'b0),
		.ext_req_set_1_in(1'b0), .irq_take_in(1'b0), .irq_vector_in(13'h0000), .irq_ack_out,
		.global_irq_enable_out);
	program_mem_model program_mem_model_i (.clk_in(sys_clk_in), .rom_addr_in(rom_addr_out),
		.rom_data_out(rom_data_in), .ram_addr_in(ram_addr_out), .ram_rd_data_out(ram_rd_data_in),
		.ram_wr_en_in(ram_wr_en_out), .ram_wr_data_in(ram_wr_data_out));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic complete_run();
		if (errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// one apb transfer: setup, then access until ready is sampled
	task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= addr;
		pwdata_in <= wdata;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		do @(posedge sys_clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic do_reset(input int n);
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		repeat (n) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		k = 0;
	endtask
	task automatic put(input logic [9:0] w);
		program_mem_model_i.rom[k] = w;
		k++;
	endtask
	// run the program into its loop, halt, read status
	task automatic run_prog(input logic [9:0] dp, input logic pol);
		apb(1'b1, 12'h004, {22'h0, dp});
		apb(1'b1, 12'h000, {28'h000_0000, pol, 3'h1});
		repeat (24) @(posedge sys_clk_in);
		apb(1'b1, 12'h000, {28'h000_0000, pol, 3'h0});
		apb(1'b0, 12'h008, 32'h0000_0000);
	endtask
	// expected {skip, carry, acc} of the operation under test
	function automatic logic [5:0] exp_op(int op, logic [3:0] a, m, n, logic c, logic [1:0] j,
		logic pin, pol);
		logic [4:0] s;
		s = (op == 6) ? a + n : a + m + ((op == 1) ? c : 1'b0);
		case (op)
			0: return {1'b0, c, s[3:0]};
			1: return {1'b0, s[4], s[3:0]};
			2: return {1'b0, c, a & m};
			3: return {1'b0, c, a | m};
			4: return {1'b0, c, ~a};
			5: return {1'b0, a[0], c, a[3:1]};
			6: return {~s[4], c, s[3:0]};
			7: return {~c, c, a};
			8: return {~m[j], c, a};
			9: return {a == m, c, a};
			10: return {a == n, c, a};
			default: return {pin == pol, c, a};
		endcase
	endfunction
	function automatic logic [9:0] op_word(int op, logic [3:0] n, logic [1:0] j);
		logic [9:0] tbl [0:11] = '{10'h00a, 10'h00b, 10'h018, 10'h019, 10'h01c, 10'h01d, 10'h060,
			10'h02f, 10'h020, 10'h026, 10'h025, 10'h03a};
		return tbl[op] | ((op == 6) ? {6'h00, n} : (op == 8) ? {8'h00, j} : 10'h000);
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin : main
		logic [3:0] a, m, n;
		logic [1:0] j;
		logic c, ei, pin, pol, setb;
		logic [9:0] dp, ri, w;
		logic [5:0] e;
		int op;
		void'($urandom(32'hd1df));
		do_reset(10);
		apb(1'b0, 12'h008, 32'h0000_0000);
		check(rd, 32'h000e_0000);
		apb(1'b0, 12'h00c, 32'h0000_0000);
		check(rd, 32'h0000_2000);
		apb(1'b1, 12'h008, 32'hffff_ffff);
		check(err, 1'b1);
		apb(1'b0, 12'h010, 32'h0000_0000);
		check({rd[30:0], err}, 32'h0000_0001);
		// long branch to page 5, short call into page 2, skipping return
		do_reset(2);
		put(10'h0e5);
		put(10'h221);
		k = 13'h02a1;
		put(10'h110);
		put(10'h007);
		put(10'h1a3);
		k = 13'h0110;
		put(10'h079);
		put(10'h045);
		run_prog(10'h000, 1'b0);
		check(rd[19:0], 20'he0009);
		apb(1'b0, 12'h00c, 32'h0000_0000);
		check(rd[12:0], 13'h02a3);
		// table read from page 3 at d:acc
		do_reset(2);
		a = 4'($urandom);
		w = {1'b1, 9'($urandom)};
		put({6'h07, a});
		put(10'h083);
		put(10'h182);
		program_mem_model_i.rom[{6'h03, 3'h0, a}] = w;
		run_prog(10'h000, 1'b0);
		check(rd[19:0], {10'h380, w});
		// random operands through every operation, followed by a bit write
		for (int i = 0; i < 48; i++) begin
			op = (i < 12) ? i : $urandom_range(11, 0);
			{a, m, n, j, c, ei, pin, pol, setb} = 19'($urandom);
			dp = 10'($urandom);
			ri = {dp[9:8], dp[3:0], dp[7:4]};
			e = exp_op(op, a, m, n, c, j, pin, pol);
			do_reset(2);
			put(c ? 10'h007 : 10'h006);
			put(ei ? 10'h005 : 10'h004);
			put({6'h07, a});
			put({6'h07, ~a});
			put(op_word(op, n, j));
			if (op == 10) begin
				put({6'h07, n});
			end
			put(setb ? {8'h17, j} : {8'h13, j});
			put({3'h3, 7'(k)});
			program_mem_model_i.ram[ri] = m;
			ext_irq_pin_0_in <= pin;
			run_prog(dp, pol);
			check(rd[11:0], {e[4], 7'h00, e[3:0]});
			check({rd[14], global_irq_enable_out}, {ei, ei});
			check(program_mem_model_i.ram[ri], e[5] ? m : setb ? m | (4'h1 << j) : m & ~(4'h1 << j));
		end
		complete_run();
	end
	// cut a hang short
	initial begin
		repeat (40000) @(posedge sys_clk_in);
		errors++;
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
